// [hw/hdp_port_interp.sv]
/*
 * Host data port interpreter: command/status bytes, the two port words,
 * input and output transfer handshakes, format decode, descriptor queues.
 * Assumes host register accesses and link-engine events share sys_clk_i.
 */
// What this block does
// - Host loads port on input, device on output
// - Port meaning follows the transfer type code
// - Four layouts: descriptor, base, control in/out
// - Address: low word plus high bits 14-15
// - Count in high bits 0-13, plain binary
// - At most seven pending descriptors per direction
// - Input descriptor adds a buffer to queue
// - Output descriptor returns each completed buffer
// - Base layout gives 256-byte table start
// - Resume clear reinitialises, set continues
// - Control layouts: address plus flag bits
// - Control bits 0-7 are station address
// - Bit 8 latches maintenance until reinitialised
// - Bit 10 selects half duplex
// - Bit 11 picks secondary, half duplex only
// - Control out bit 0 flags retry limit
// - Type plus request bit gets grant bit
// - Request drop: capture and release grant
// - Output: load port, type, pending flag
`timescale 1ns/100ps
`default_nettype none

module hdp_port_interp #(
	parameter int QDEPTH = hdp_pkg::QUEUE_DEPTH
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic host_sel_i,
	input wire logic host_we_i,
	input wire logic [2:0] host_addr_i,
	input wire logic [15:0] host_wdata_i,
	output logic [15:0] host_rdata_o,
	input wire logic done_valid_i,
	input wire logic done_dir_i,
	output logic done_ready_o,
	input wire logic retry_limit_i,
	output logic tx_head_valid_o,
	output logic [hdp_pkg::ADDR_W-1:0] tx_head_addr_o,
	output logic [hdp_pkg::CNT_W-1:0] tx_head_count_o,
	output logic rx_head_valid_o,
	output logic [hdp_pkg::ADDR_W-1:0] rx_head_addr_o,
	output logic [hdp_pkg::CNT_W-1:0] rx_head_count_o,
	output logic [hdp_pkg::STN_W-1:0] station_addr_o,
	output logic maint_mode_o,
	output logic half_duplex_o,
	output logic secondary_role_o,
	output logic [hdp_pkg::ADDR_W-1:0] ctrl_addr_o,
	output logic [hdp_pkg::ADDR_W-1:0] base_addr_o,
	output logic initialized_o,
	output logic proto_init_o,
	output logic proto_resume_o
);
	import hdp_pkg::*;

	localparam int DW = ADDR_W + CNT_W;

	function automatic logic is_buf_type(input logic [2:0] t);
		return (t == TYPE_BUF_TX) || (t == TYPE_BUF_RX);
	endfunction

	function automatic logic [ADDR_W-1:0] word_addr(input logic [15:0] lo, input logic [15:0] hi);
		return {hi[15:EXT_LSB], lo};
	endfunction

	hdp_port_e state_q;
	logic [2:0] cmd_type_q;
	logic req_q;
	logic grant_q;
	logic [2:0] grant_type_q;
	logic [2:0] out_type_q;
	logic out_pend_q;
	logic [15:0] port_low_word_q;
	logic [15:0] port_high_word_q;
	logic [DW-1:0] ret_desc_q;
	logic ret_dir_q;
	logic err_pend_q;

	logic wr_cmd;
	logic wr_stat;
	logic wr_low;
	logic wr_high;
	logic host_clr_out;
	logic can_grant;
	logic do_grant;
	logic do_capture;
	logic load_err;
	logic load_ret;
	logic base_cold;
	logic done_take;
	logic tx_full;
	logic rx_full;
	logic [DW-1:0] cap_desc;
	logic [DW-1:0] tx_head;
	logic [DW-1:0] rx_head;

	assign wr_cmd = host_sel_i && host_we_i && host_addr_i == ADDR_CMD;
	assign wr_stat = host_sel_i && host_we_i && host_addr_i == ADDR_STAT;
	assign wr_low = host_sel_i && host_we_i && host_addr_i == ADDR_LOW;
	assign wr_high = host_sel_i && host_we_i && host_addr_i == ADDR_HIGH;
	assign host_clr_out = wr_stat && !host_wdata_i[OUT_PEND_BIT];

	// Full descriptor queue holds the grant back until room appears
	assign can_grant = !is_buf_type(cmd_type_q) ||
		(cmd_type_q[DIR_BIT] ? !rx_full : !tx_full);
	assign do_grant = state_q == PORT_IDLE && req_q && can_grant;
	// Capture when the host drops its request on a granted port
	assign do_capture = state_q == PORT_GRANTED && !req_q;
	// Output seizes the port only if no grantable request waits
	assign load_err = state_q == PORT_IDLE && !do_grant && initialized_o && err_pend_q;
	assign load_ret = state_q == PORT_IDLE && !do_grant && initialized_o && !err_pend_q && !done_ready_o;
	assign base_cold = do_capture && grant_type_q == TYPE_BASE && !port_high_word_q[RESUME_BIT];
	assign done_take = done_valid_i && done_ready_o && (done_dir_i ? rx_head_valid_o : tx_head_valid_o);
	// Address from bits 0-15 low and 14-15 high; count in 0-13
	assign cap_desc = {word_addr(port_low_word_q, port_high_word_q), port_high_word_q[CNT_W-1:0]};

	hdp_desc_queue #(
		.DEPTH(QDEPTH),
		.W(DW)
	) u_tx_queue (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.clear_i(base_cold),
		.push_i(do_capture && grant_type_q == TYPE_BUF_TX),
		.push_data_i(cap_desc),
		.pop_i(done_take && !done_dir_i),
		.head_o(tx_head),
		.valid_o(tx_head_valid_o),
		.full_o(tx_full)
	);

	hdp_desc_queue #(
		.DEPTH(QDEPTH),
		.W(DW)
	) u_rx_queue (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.clear_i(base_cold),
		.push_i(do_capture && grant_type_q == TYPE_BUF_RX),
		.push_data_i(cap_desc),
		.pop_i(done_take && done_dir_i),
		.head_o(rx_head),
		.valid_o(rx_head_valid_o),
		.full_o(rx_full)
	);

	assign tx_head_addr_o = tx_head[DW-1:CNT_W];
	assign tx_head_count_o = tx_head[CNT_W-1:0];
	assign rx_head_addr_o = rx_head[DW-1:CNT_W];
	assign rx_head_count_o = rx_head[CNT_W-1:0];

	// Command byte belongs to the host
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_type_q <= RST_TYPE;
			req_q <= 1'b0;
		end else if (ce_i && wr_cmd) begin
			cmd_type_q <= host_wdata_i[TYPE_W-1:0];
			req_q <= host_wdata_i[REQ_BIT];
		end
	end

	// Port ownership sequence
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= PORT_IDLE;
			grant_q <= 1'b0;
			grant_type_q <= RST_TYPE;
		end else if (ce_i) begin
			unique case (state_q)
				PORT_IDLE: begin
					if (do_grant) begin
						state_q <= PORT_GRANTED;
						grant_q <= 1'b1;
						grant_type_q <= cmd_type_q;
					end else if (load_err || load_ret) begin
						state_q <= PORT_OUTPUT;
					end
				end
				PORT_GRANTED: begin
					if (do_capture) begin
						state_q <= PORT_IDLE;
						grant_q <= 1'b0;
					end
				end
				PORT_OUTPUT: begin
					if (!out_pend_q) begin
						state_q <= PORT_IDLE;
					end
				end
				// Spare code only from an upset; drop back to idle
				default: begin
					state_q <= PORT_IDLE;
					grant_q <= 1'b0;
				end
			endcase
		end
	end

	// Port words: host writes only while granted, device only on output
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			port_low_word_q <= RST_WORD;
			port_high_word_q <= RST_WORD;
		end else if (ce_i) begin
			if (load_err) begin
				port_low_word_q <= ctrl_addr_o[15:0];
				port_high_word_q <= {ctrl_addr_o[ADDR_W-1:16], 13'h0000, 1'b1};
			end else if (load_ret) begin
				port_low_word_q <= ret_desc_q[CNT_W+15:CNT_W];
				port_high_word_q <= {ret_desc_q[DW-1:CNT_W+16], ret_desc_q[CNT_W-1:0]};
			end else if (state_q == PORT_GRANTED) begin
				if (wr_low) begin
					port_low_word_q <= host_wdata_i;
				end
				if (wr_high) begin
					port_high_word_q <= host_wdata_i;
				end
			end
		end
	end

	// Status byte; host may only clear the pending flag
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_pend_q <= 1'b0;
			out_type_q <= RST_TYPE;
		end else if (ce_i) begin
			if (load_err || load_ret) begin
				out_pend_q <= 1'b1;
				out_type_q <= load_err ? TYPE_CTRL : (ret_dir_q ? TYPE_BUF_RX : TYPE_BUF_TX);
			end else if (host_clr_out) begin
				out_pend_q <= 1'b0;
			end
		end
	end

	// Return slot for one completed buffer
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			done_ready_o <= 1'b1;
			ret_dir_q <= 1'b0;
			ret_desc_q <= '0;
		end else if (ce_i) begin
			if (done_take) begin
				done_ready_o <= 1'b0;
				ret_dir_q <= done_dir_i;
				ret_desc_q <= done_dir_i ? rx_head : tx_head;
			end else if (load_ret || base_cold) begin
				done_ready_o <= 1'b1;
			end
		end
	end

	// New event beats the clear from loading or cold start
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			err_pend_q <= 1'b0;
		end else if (ce_i) begin
			if (retry_limit_i) begin
				err_pend_q <= 1'b1;
			end else if (load_err || base_cold) begin
				err_pend_q <= 1'b0;
			end
		end
	end

	// Base table assignment; the host keeps out of the table itself
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			base_addr_o <= '0;
			initialized_o <= 1'b0;
			proto_init_o <= 1'b0;
			proto_resume_o <= 1'b0;
		end else if (ce_i) begin
			// Single-cycle pulses; the link engine must latch them
			proto_init_o <= base_cold;
			proto_resume_o <= 1'b0;
			if (do_capture && grant_type_q == TYPE_BASE) begin
				base_addr_o <= word_addr(port_low_word_q, port_high_word_q);
				initialized_o <= 1'b1;
				proto_resume_o <= port_high_word_q[RESUME_BIT];
			end
		end
	end

	// Control input; reserved bits never reach any mode flop
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			station_addr_o <= '0;
			half_duplex_o <= 1'b0;
			secondary_role_o <= 1'b0;
			ctrl_addr_o <= '0;
		end else if (ce_i && do_capture && grant_type_q == TYPE_CTRL) begin
			ctrl_addr_o <= word_addr(port_low_word_q, port_high_word_q);
			station_addr_o <= port_high_word_q[STN_W-1:0];
			half_duplex_o <= port_high_word_q[HDX_BIT];
			secondary_role_o <= port_high_word_q[HDX_BIT] && port_high_word_q[SEC_BIT];
		end
	end

	// Maintenance sticks until a cold base assignment
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			maint_mode_o <= 1'b0;
		end else if (ce_i) begin
			if (do_capture && grant_type_q == TYPE_CTRL && port_high_word_q[MAINT_BIT]) begin
				maint_mode_o <= 1'b1;
			end else if (base_cold) begin
				maint_mode_o <= 1'b0;
			end
		end
	end

	// Registered read; one cycle of latency
	// Odd and spare offsets read zero
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			host_rdata_o <= RST_WORD;
		end else if (ce_i && host_sel_i && !host_we_i) begin
			unique case (host_addr_i)
				ADDR_CMD: host_rdata_o <= {8'h00, grant_q, 1'b0, req_q, 2'b00, cmd_type_q};
				ADDR_STAT: host_rdata_o <= {8'h00, out_pend_q, 4'h0, out_type_q};
				ADDR_LOW: host_rdata_o <= port_low_word_q;
				ADDR_HIGH: host_rdata_o <= port_high_word_q;
				default: host_rdata_o <= RST_WORD;
			endcase
		end
	end

endmodule

`default_nettype wire

// [hw/hdp_pkg.sv]
/*
 * Constants for the host data port interpreter: port offsets, field
 * positions, transfer type codes, reset values and queue sizes.
 * Assumes a 16-bit host register port with byte offsets on even addresses.
 */
package hdp_pkg;

	// Host register offsets, bytes
	localparam logic [2:0] ADDR_CMD = 3'h0;
	localparam logic [2:0] ADDR_STAT = 3'h2;
	localparam logic [2:0] ADDR_LOW = 3'h4;
	localparam logic [2:0] ADDR_HIGH = 3'h6;

	// Command and status byte fields
	localparam int TYPE_W = 3;
	localparam int REQ_BIT = 5;
	localparam int GRANT_BIT = 7;
	localparam int OUT_PEND_BIT = 7;

	// High port word fields
	localparam int ADDR_W = 18;
	localparam int CNT_W = 14;
	localparam int EXT_LSB = 14;
	localparam int RESUME_BIT = 13;
	localparam int STN_W = 8;
	localparam int MAINT_BIT = 8;
	localparam int HDX_BIT = 10;
	localparam int SEC_BIT = 11;
	localparam int RETRY_BIT = 0;

	// Transfer type codes; bit 2 marks the receive direction
	localparam logic [2:0] TYPE_BUF_TX = 3'h0;
	localparam logic [2:0] TYPE_CTRL = 3'h1;
	localparam logic [2:0] TYPE_BASE = 3'h3;
	localparam logic [2:0] TYPE_BUF_RX = 3'h4;
	localparam int DIR_BIT = 2;

	// Queue and reset values
	localparam int QUEUE_DEPTH = 7;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [2:0] RST_TYPE = 3'h0;

	// Port hand-back bound after the request drops
	localparam int CAPTURE_LIMIT_NS = 10_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CAPTURE_LIMIT_CYC = CAPTURE_LIMIT_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PORT_IDLE,
		PORT_GRANTED,
		PORT_OUTPUT
	} hdp_port_e;

endpackage

// [hw/hdp_desc_queue.sv]
/*
 * Shift-style descriptor queue; entry 0 is always the head, so the head
 * and its flags come straight from flip-flops.
 * Assumes the caller never pushes while full nor pops while empty.
 */
`timescale 1ns/100ps
`default_nettype none

module hdp_desc_queue #(
	parameter int DEPTH = 7,
	parameter int W = 32
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic clear_i,
	input wire logic push_i,
	input wire logic [W-1:0] push_data_i,
	input wire logic pop_i,
	output logic [W-1:0] head_o,
	output logic valid_o,
	output logic full_o
);
	logic [W-1:0] entry_q [DEPTH];
	logic [W-1:0] entry_d [DEPTH];
	logic [$clog2(DEPTH+1)-1:0] count_q;
	logic [$clog2(DEPTH+1)-1:0] count_d;
	logic [$clog2(DEPTH+1)-1:0] wr_idx;

	always_comb begin
		count_d = count_q;
		if (push_i && !pop_i) begin
			count_d = count_q + 1'b1;
		end else if (pop_i && !push_i) begin
			count_d = count_q - 1'b1;
		end
		wr_idx = pop_i ? count_q - 1'b1 : count_q;
		for (int i = 0; i < DEPTH; i++) begin
			entry_d[i] = (pop_i && i < DEPTH - 1) ? entry_q[i+1] : entry_q[i];
			if (push_i && wr_idx == i[$clog2(DEPTH+1)-1:0]) begin
				entry_d[i] = push_data_i;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_q <= '0;
			valid_o <= 1'b0;
			full_o <= 1'b0;
		end else if (ce_i) begin
			if (clear_i) begin
				count_q <= '0;
				valid_o <= 1'b0;
				full_o <= 1'b0;
			end else begin
				count_q <= count_d;
				valid_o <= (count_d != '0);
				full_o <= (count_d == DEPTH[$clog2(DEPTH+1)-1:0]);
			end
		end
	end

	// Storage needs no reset; valid_o guards it
	always_ff @(posedge sys_clk_i) begin
		if (ce_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				entry_q[i] <= entry_d[i];
			end
		end
	end

	assign head_o = entry_q[0];

endmodule

`default_nettype wire

// [bench/hdp_port_interp_assertions.sv]
/* Checker for hdp_port_interp, bound to its ports.
   Assumes one clock domain and the bind below. */
`timescale 1ns/100ps
`default_nettype none
module hdp_chk (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic host_sel_i,
	input wire logic host_we_i,
	input wire logic [2:0] host_addr_i,
	input wire logic [15:0] host_rdata_o,
	input wire logic done_valid_i,
	input wire logic done_dir_i,
	input wire logic done_ready_o,
	input wire logic tx_head_valid_o,
	input wire logic rx_head_valid_o,
	input wire logic maint_mode_o,
	input wire logic half_duplex_o,
	input wire logic secondary_role_o,
	input wire logic initialized_o,
	input wire logic proto_init_o,
	input wire logic proto_resume_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	wire logic rd = ce_i && host_sel_i && !host_we_i;
	wire logic hv = done_dir_i ? rx_head_valid_o : tx_head_valid_o;

	a_role_needs_hdx: assert property (secondary_role_o |-> half_duplex_o)
		else $error("secondary role in full duplex");
	a_start_one_cycle: assert property (proto_init_o |=> !proto_init_o && !proto_resume_o)
		else $error("init pulse too long");
	a_start_exclusive: assert property (!(proto_init_o && proto_resume_o))
		else $error("init and resume together");
	a_start_marks_init: assert property (proto_init_o || proto_resume_o |-> ##[0:1] initialized_o)
		else $error("start without initialized");
	// Only a fresh start may leave maintenance
	a_maint_holds: assert property ($fell(maint_mode_o) |-> proto_init_o || $past(proto_init_o))
		else $error("maintenance left early");
	a_done_takes_slot: assert property (done_valid_i && done_ready_o && ce_i && hv |=> !done_ready_o)
		else $error("return slot not taken");
	a_rdata_holds: assert property (!rd |=> $stable(host_rdata_o))
		else $error("read data moved");
	a_odd_reads_zero: assert property (rd && host_addr_i[0] |=> host_rdata_o == 16'h0000)
		else $error("odd offset read not zero");
endmodule

bind hdp_port_interp hdp_chk u_chk (.sys_clk_i, .resetn_i, .ce_i, .host_sel_i, .host_we_i,
	.host_addr_i, .host_rdata_o, .done_valid_i, .done_dir_i, .done_ready_o, .tx_head_valid_o,
	.rx_head_valid_o, .maint_mode_o, .half_duplex_o, .secondary_role_o, .initialized_o,
	.proto_init_o, .proto_resume_o);
`default_nettype wire

// [bench/hdp_host_model.sv]
/* Host program model: register accesses and port transfers.
   Assumes the bench calls its tasks one at a time; acc makes one access per call. */
`timescale 1ns/100ps
`default_nettype none
module hdp_host (
	input wire logic clk_i,
	input wire logic [15:0] rdata_i,
	output logic sel_o,
	output logic we_o,
	output logic [2:0] addr_o,
	output logic [15:0] wdata_o
);
	import hdp_pkg::*;
	initial begin
		sel_o = 1'b0;
		we_o = 1'b0;
		addr_o = 3'h0;
		wdata_o = 16'h0000;
	end
	// Data inverted on release so stale values never look valid
	task automatic acc(input logic w, input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
		@(negedge clk_i);
		sel_o = 1'b1;
		we_o = w;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		sel_o = 1'b0;
		wdata_o = ~d;
		q = rdata_i;
	endtask
	task automatic poll(input logic [2:0] a, input logic w, output logic ok, output logic [15:0] q);
		ok = 1'b0;
		repeat (12) begin
			acc(1'b0, a, 16'h0000, q);
			ok = (q[7] === w);
			if (ok) break;
		end
	endtask
	// Only command byte and port words are written; table memory never touched
	task automatic xfer_in(input logic [2:0] t, input logic [15:0] lo, hi, output logic ok);
		logic [15:0] q;
		acc(1'b1, ADDR_CMD, 16'h0020 | t, q);
		poll(ADDR_CMD, 1'b1, ok, q);
		if (ok) begin
			acc(1'b1, ADDR_LOW, lo, q);
			acc(1'b1, ADDR_HIGH, hi, q);
		end
		acc(1'b1, ADDR_CMD, 16'h0000 | t, q);
		if (ok) poll(ADDR_CMD, 1'b0, ok, q);
	endtask
	task automatic take_out(output logic [2:0] t, output logic [15:0] lo, hi, output logic ok);
		logic [15:0] q;
		poll(ADDR_STAT, 1'b1, ok, q);
		t = q[2:0];
		acc(1'b0, ADDR_LOW, 16'h0000, lo);
		acc(1'b0, ADDR_HIGH, 16'h0000, hi);
		acc(1'b1, ADDR_STAT, 16'h0000, q);
	endtask
endmodule
`default_nettype wire

// [bench/hdp_port_interp_tb_top.sv]
/* Self-checking bench for hdp_port_interp.
   Assumes hdp_host drives the host port; link events driven here. */
`timescale 1ns/100ps
`default_nettype none
module hdp_port_interp_tb_top;
	import hdp_pkg::*;
	logic sys_clk_i = 0, resetn_i = 0, done_valid_i = 0, done_dir_i = 0, retry_limit_i = 0;
	logic host_sel_i, host_we_i, done_ready_o, tx_head_valid_o, rx_head_valid_o, maint_mode_o;
	logic half_duplex_o, secondary_role_o, initialized_o, proto_init_o, proto_resume_o, ok, si, sr;
	logic [2:0] host_addr_i, ty;
	logic [7:0] station_addr_o;
	logic [13:0] tx_head_count_o, rx_head_count_o;
	logic [15:0] host_wdata_i, host_rdata_o, lo, hi, fl, fh, q, s = 16'h4778;
	logic [17:0] tx_head_addr_o, rx_head_addr_o, ctrl_addr_o, base_addr_o, ce;
	int bad_count = 0, check_count = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	hdp_port_interp dut (.sys_clk_i, .resetn_i, .ce_i(1'b1), .host_sel_i, .host_we_i, .host_addr_i,
		.host_wdata_i, .host_rdata_o, .done_valid_i, .done_dir_i, .done_ready_o, .retry_limit_i,
		.tx_head_valid_o, .tx_head_addr_o, .tx_head_count_o, .rx_head_valid_o, .rx_head_addr_o,
		.rx_head_count_o, .station_addr_o, .maint_mode_o, .half_duplex_o, .secondary_role_o,
		.ctrl_addr_o, .base_addr_o, .initialized_o, .proto_init_o, .proto_resume_o);
	hdp_host host (.clk_i(sys_clk_i), .rdata_i(host_rdata_o), .sel_o(host_sel_i), .we_o(host_we_i),
		.addr_o(host_addr_i), .wdata_o(host_wdata_i));
	// One-cycle pulses latched so slow polling cannot miss them
	always @(posedge sys_clk_i) begin
		if (proto_init_o) si <= 1'b1;
		if (proto_resume_o) sr <= 1'b1;
	end
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [31:0] desc_of(input logic [15:0] l, input logic [15:0] h);
		return {h[15:14], l, h[13:0]};
	endfunction
	task automatic rnd();
		s = nx(s);
		lo = s;
		s = nx(s);
		hi = s;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic done(input logic d);
		@(negedge sys_clk_i);
		done_valid_i = 1'b1;
		done_dir_i = d;
		@(negedge sys_clk_i);
		done_valid_i = 1'b0;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Whole run needs a few hundred cycles; limit leaves wide margin
	initial begin
		#200_000;
		bad_count++;
		give_verdict();
	end
	initial begin
		si = 1'b0;
		sr = 1'b0;
		repeat (6) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		chk({done_ready_o, tx_head_valid_o, initialized_o}, 3'h4);
		host.acc(1'b1, ADDR_LOW, 16'h5a5a, q);
		host.acc(1'b0, ADDR_LOW, 16'h0000, q);
		chk(q, 16'h0000);
		host.acc(1'b0, 3'h5, 16'h0000, q);
		chk(q, 16'h0000);
		$display("test reset done");
		rnd();
		host.xfer_in(TYPE_BASE, lo, hi & 16'hdfff, ok);
		chk({ok, si, initialized_o, base_addr_o}, {3'h7, hi[15:14], lo});
		host.xfer_in(TYPE_BASE, lo, hi | 16'h2000, ok);
		chk({ok, sr, base_addr_o}, {2'h3, hi[15:14], lo});
		host.xfer_in(3'h2, ~lo, ~hi, ok);
		chk({ok, base_addr_o}, {1'b1, hi[15:14], lo});
		$display("test base done");
		// Reserved bits 9, 12, 13 stay random
		for (int i = 0; i < 4; i++) begin
			rnd();
			hi[11:10] = i[1:0];
			hi[8] = (i == 1);
			ce = {hi[15:14], lo};
			host.xfer_in(TYPE_CTRL, lo, hi, ok);
			chk({ok, station_addr_o, half_duplex_o, secondary_role_o, maint_mode_o, ctrl_addr_o},
				{1'b1, hi[7:0], hi[10], hi[10] & hi[11], i > 0, ce});
		end
		host.xfer_in(TYPE_BASE, lo, 16'h0000, ok);
		chk(maint_mode_o, 1'b0);
		$display("test control done");
		for (int i = 0; i < 8; i++) begin
			rnd();
			if (i == 0) {fl, fh} = {lo, hi};
			host.xfer_in(TYPE_BUF_TX, lo, hi, ok);
			chk(ok, i < 7);
		end
		chk({tx_head_valid_o, tx_head_addr_o, tx_head_count_o}, {1'b1, desc_of(fl, fh)});
		done(1'b0);
		host.take_out(ty, lo, hi, ok);
		chk({ok, ty, lo, hi}, {1'b1, TYPE_BUF_TX, fl, fh});
		host.xfer_in(TYPE_BUF_TX, lo, hi, ok);
		chk(ok, 1'b1);
		rnd();
		host.xfer_in(TYPE_BUF_RX, lo, hi, ok);
		chk({rx_head_valid_o, rx_head_addr_o, rx_head_count_o}, {1'b1, desc_of(lo, hi)});
		{fl, fh} = {lo, hi};
		done(1'b1);
		host.take_out(ty, lo, hi, ok);
		chk({ok, ty, lo, hi, rx_head_valid_o}, {1'b1, TYPE_BUF_RX, fl, fh, 1'b0});
		$display("test buffers done");
		@(negedge sys_clk_i);
		retry_limit_i = 1'b1;
		@(negedge sys_clk_i);
		retry_limit_i = 1'b0;
		host.take_out(ty, lo, hi, ok);
		chk({ok, ty, lo, hi}, {1'b1, TYPE_CTRL, ce[15:0], ce[17:16], 13'h0000, 1'b1});
		$display("test error report done");
		give_verdict();
	end
endmodule
`default_nettype wire
